// *** ism_pkg.sv ***
// Shared constants and types for the interrupt source map.
package ism_pkg;

  // Line counts and widths.
  localparam int ISM_LINES   = 32;
  localparam int ISM_PINS    = 12;
  localparam int ISM_SRCS    = 24;
  localparam int ISM_LEVELS  = 4;

  // Line numbers of the vectored lines.
  localparam int ISM_LINE_TIMER    = 0;
  localparam int ISM_LINE_RADIO    = 2;
  localparam int ISM_LINE_BYTEMEM  = 3;
  localparam int ISM_LINE_HOST     = 6;
  localparam int ISM_LINE_CONTACT  = 7;
  localparam int ISM_LINE_POWER    = 9;
  localparam int ISM_LINE_SPIM     = 10;
  localparam int ISM_LINE_TWIM     = 11;
  localparam int ISM_LINE_PCRU     = 12;
  localparam int ISM_LINE_PINCOM   = 13;
  localparam int ISM_LINE_PIN0     = 14;

  // Lines that are reserved and must stay quiet.
  localparam logic [31:0] ISM_RESERVED_MASK = 32'hfc00_0132;

  // Bit positions of the peripheral requests in the raw source vector.
  localparam int ISM_SRC_TIMER   = 0;
  localparam int ISM_SRC_RADIO   = 4;
  localparam int ISM_SRC_BYTEMEM = 5;
  localparam int ISM_SRC_HOST    = 6;
  localparam int ISM_SRC_CONTACT = 10;
  localparam int ISM_SRC_POWER   = 11;
  localparam int ISM_SRC_SPIM    = 15;
  localparam int ISM_SRC_TWIM    = 16;
  localparam int ISM_SRC_PCRU    = 17;
  localparam int ISM_SRC_WDOG    = 23;

  // Active level value meaning that no handler runs.
  localparam logic [2:0] ISM_NO_LEVEL = 3'h4;

  // Reset values.
  localparam logic [31:0] ISM_PEND_RST   = 32'h0000_0000;
  localparam logic [3:0]  ISM_ACTIVE_RST = 4'h0;

  // Trigger modes of a sensed input.
  typedef enum logic [2:0] {
    TRIG_RISE,
    TRIG_FALL,
    TRIG_BOTH,
    TRIG_HIGH,
    TRIG_LOW
  } ism_trig_t;

  // Dispatch states.
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_OFFER
  } ism_state_t;

endpackage : ism_pkg

// *** ism_pin_sense.sv ***
// Synchroniser and edge or level detector for one request input.
`timescale 1ns/1ps
`default_nettype none

module ism_pin_sense (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Raw request and its trigger mode.
  input  wire logic              rawIn,
  input  var  ism_pkg::ism_trig_t mode,
  // Detected event, three cycles after the raw input.
  output logic                   event_o
);
  import ism_pkg::*;

  logic s1;
  logic s2;
  logic s3;
  logic next_s1;
  logic next_s2;
  logic next_s3;
  logic next_event;

  // The first stage feeds only the second; detection looks at later stages.
  always_comb begin
    next_s1 = rawIn;
    next_s2 = s1;
    next_s3 = s2;
    case (mode)
      TRIG_RISE: next_event = s2 & ~s3;
      TRIG_FALL: next_event = ~s2 & s3;
      TRIG_BOTH: next_event = s2 ^ s3;
      TRIG_HIGH: next_event = s2;
      TRIG_LOW:  next_event = ~s2;
      default:   next_event = 1'b0;
    endcase
  end

  // Registering the event keeps every source at the same latency.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      event_o <= 1'b0;
    end else begin
      s1      <= next_s1;
      s2      <= next_s2;
      s3      <= next_s3;
      event_o <= next_event;
    end
  end

endmodule : ism_pin_sense
`default_nettype wire

// *** ism_interrupt_source_map.sv ***
// Interrupt source map with pending, priority masking and dispatch to the core.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Thirty-two numbered lines, each separately enabled and dispatched to the core.
// RULE2: Four priority levels; requests at or below the active level are masked.
// RULE3: One non-maskable request, driven by the watchdog timer.
// RULE4: Handles exceptions and peripheral lines; software may set a line pending.
// RULE5: Line 0 is the OR of the four timer requests.
// RULE6: Line 2 carries the contactless front end request.
// RULE7: Line 6 carries the host interface buffer event of any variant.
// RULE8: Line 7 carries the contact smart card request.
// RULE9: Line 9 carries the power management unit request.
// RULE10: Line 10 carries the four-wire serial master buffer event.
// RULE11: Line 11 carries the two-wire serial master buffer event.
// RULE12: Line 12 carries the power clock reset unit events.
// RULE13: Line 13 is the common request of general pins 1 to 12.
// RULE14: Lines 14 to 25 carry pins 1 to 12, each with programmable trigger.
// RULE15: The non-maskable request has no external pin; only the watchdog drives it.
// RULE16: Line 3 carries the byte memory controller; reserved lines stay quiet.
// RULE17: Every request is synchronised to the core clock before use.
module ism_interrupt_source_map (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst,
  // Peripheral requests.
  input  wire logic [3:0]          timerIrq,
  input  wire logic                radioIrq,
  input  wire logic                byteMemIrq,
  input  wire logic [3:0]          hostBufIrq,
  input  wire logic                contactIrq,
  input  wire logic [3:0]          powerIrq,
  input  wire logic                spiMasterIrq,
  input  wire logic                twiMasterIrq,
  input  wire logic [5:0]          pcrIrq,
  input  wire logic                watchdogIrq,
  // General pins and their trigger modes.
  input  wire logic [11:0]         pinIn,
  input  var  ism_pkg::ism_trig_t  pinMode [ism_pkg::ISM_PINS],
  // Line configuration from the core.
  input  wire logic [31:0]         lineEnable,
  input  wire logic [1:0]          linePriority [ism_pkg::ISM_LINES],
  input  wire logic [31:0]         swSetPend,
  // Dispatch handshake with the core.
  output logic                     irqValid,
  output logic [4:0]               irqNum,
  output logic [1:0]               irqLevel,
  input  wire logic                irqAck,
  input  wire logic                excReturn,
  // Status.
  output logic [31:0]              pendingOut,
  output logic [3:0]               activeMask,
  output logic                     nmiReq
);
  import ism_pkg::*;

  logic [ISM_SRCS-1:0]  srcRaw;
  logic [ISM_SRCS-1:0]  srcEvt;
  logic [ISM_PINS-1:0]  pinEvt;
  logic [31:0]          hwLine;
  logic [31:0]          pending;
  logic [31:0]          next_pending;
  logic [31:0]          ackClr;
  logic [3:0]           next_activeMask;
  logic [2:0]           activeLevel;
  ism_state_t           state;
  ism_state_t           next_state;
  logic [4:0]           next_irqNum;
  logic [1:0]           next_irqLevel;
  logic                 found;
  logic [4:0]           bestNum;
  logic [1:0]           bestPrio;

  // Raw peripheral requests gathered in one vector for synchronising.
  assign srcRaw = {watchdogIrq, pcrIrq, twiMasterIrq, spiMasterIrq, powerIrq,
                   contactIrq, hostBufIrq, byteMemIrq, radioIrq, timerIrq};

  // Peripheral requests are level sensitive; each passes a synchroniser.
  for (genvar g = 0; g < ISM_SRCS; g++) begin : gSrc
    ism_pin_sense uSrc (  // see RULE17
      .clk     (clk),
      .rst     (rst),
      .rawIn   (srcRaw[g]),
      .mode    (TRIG_HIGH),
      .event_o (srcEvt[g])
    );
  end

  // Each general pin has its own programmable trigger.
  for (genvar p = 0; p < ISM_PINS; p++) begin : gPin
    ism_pin_sense uPin (  // see RULE14
      .clk     (clk),
      .rst     (rst),
      .rawIn   (pinIn[p]),
      .mode    (pinMode[p]),
      .event_o (pinEvt[p])
    );
  end

  // Map the synchronised sources onto numbered lines; unnamed lines stay low.
  always_comb begin
    hwLine                   = '0;  // see RULE16
    hwLine[ISM_LINE_TIMER]   = |srcEvt[ISM_SRC_TIMER +: 4];  // see RULE5
    hwLine[ISM_LINE_RADIO]   = srcEvt[ISM_SRC_RADIO];  // see RULE6
    hwLine[ISM_LINE_BYTEMEM] = srcEvt[ISM_SRC_BYTEMEM];  // see RULE16
    hwLine[ISM_LINE_HOST]    = |srcEvt[ISM_SRC_HOST +: 4];  // see RULE7
    hwLine[ISM_LINE_CONTACT] = srcEvt[ISM_SRC_CONTACT];  // see RULE8
    hwLine[ISM_LINE_POWER]   = |srcEvt[ISM_SRC_POWER +: 4];  // see RULE9
    hwLine[ISM_LINE_SPIM]    = srcEvt[ISM_SRC_SPIM];  // see RULE10
    hwLine[ISM_LINE_TWIM]    = srcEvt[ISM_SRC_TWIM];  // see RULE11
    hwLine[ISM_LINE_PCRU]    = |srcEvt[ISM_SRC_PCRU +: 6];  // see RULE12
    hwLine[ISM_LINE_PINCOM]  = |pinEvt;  // see RULE13
    hwLine[ISM_LINE_PIN0 +: ISM_PINS] = pinEvt;  // see RULE14
  end

  // The watchdog is the only driver of the non-maskable request; no pin reaches it.
  assign nmiReq = srcEvt[ISM_SRC_WDOG];  // see RULE3 see RULE15

  // Active level is the most urgent level in service, or none.
  always_comb begin
    activeLevel = ISM_NO_LEVEL;
    for (int l = ISM_LEVELS - 1; l >= 0; l--) begin
      if (activeMask[l]) begin
        activeLevel = 3'(l);
      end
    end
  end

  // Pick the most urgent eligible line; ties go to the lower line number.
  always_comb begin
    found    = 1'b0;
    bestNum  = 5'h0;
    bestPrio = 2'h3;
    for (int i = ISM_LINES - 1; i >= 0; i--) begin
      if (pending[i] && lineEnable[i] && ({1'b0, linePriority[i]} < activeLevel)  // see RULE2
          && (!found || linePriority[i] <= bestPrio)) begin
        found    = 1'b1;
        bestNum  = 5'(i);
        bestPrio = linePriority[i];
      end
    end
  end

  // The offer is withdrawn at once if its line is disabled or becomes masked.
  assign irqValid = (state == ST_OFFER) && lineEnable[irqNum]  // see RULE1
                    && ({1'b0, irqLevel} < activeLevel);

  // Dispatch sequence and nesting of active levels.
  always_comb begin
    next_state      = state;
    next_irqNum     = irqNum;
    next_irqLevel   = irqLevel;
    next_activeMask = activeMask;
    ackClr          = '0;
    // A return retires the most urgent level before any new one is taken.
    if (excReturn && activeLevel != ISM_NO_LEVEL) begin
      next_activeMask[activeLevel[1:0]] = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (found) begin
          next_state    = ST_OFFER;
          next_irqNum   = bestNum;
          next_irqLevel = bestPrio;
        end
      end
      ST_OFFER: begin
        if (irqValid && irqAck) begin
          ackClr[irqNum]            = 1'b1;  // see RULE1
          next_activeMask[irqLevel] = 1'b1;  // see RULE2
          next_state                = ST_IDLE;
        end else if (!irqValid) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // New requests win over the acknowledge clear, so none is lost.
  always_comb begin
    next_pending = (pending & ~ackClr) | hwLine | swSetPend;  // see RULE4
    next_pending = next_pending & ~ISM_RESERVED_MASK;  // see RULE16
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      irqNum     <= 5'h0;
      irqLevel   <= 2'h0;
      activeMask <= ISM_ACTIVE_RST;
      pending    <= ISM_PEND_RST;
    end else begin
      state      <= next_state;
      irqNum     <= next_irqNum;
      irqLevel   <= next_irqLevel;
      activeMask <= next_activeMask;
      pending    <= next_pending;
    end
  end

  assign pendingOut = pending;

  // Checks on the mapping and the dispatch.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence pin0_rise_s;
    (pinMode[0] == TRIG_RISE) && !pinIn[0] ##1 (pinMode[0] == TRIG_RISE) && pinIn[0];
  endsequence

  sequence take_s;
    irqValid && irqAck;
  endsequence

  timer_or_line_a: assert property (  // see RULE5
    hwLine[ISM_LINE_TIMER] == |$past(timerIrq, 3))
    else $error("Line 0 does not follow the timer requests.");

  host_line_a: assert property (  // see RULE7
    hwLine[ISM_LINE_HOST] == |$past(hostBufIrq, 3))
    else $error("Line 6 does not follow the host buffer events.");

  watchdog_nmi_a: assert property (  // see RULE3
    nmiReq == $past(watchdogIrq, 3))
    else $error("Non-maskable request does not follow the watchdog.");

  reserved_quiet_a: assert property (  // see RULE16
    (pending & ISM_RESERVED_MASK) == 32'h0000_0000)
    else $error("A reserved line became pending.");

  pin_common_a: assert property (  // see RULE13
    hwLine[ISM_LINE_PINCOM] == |hwLine[ISM_LINE_PIN0 +: ISM_PINS])
    else $error("Common pin line differs from the pin lines.");

  pin_rise_a: assert property (  // see RULE14
    pin0_rise_s |-> ##3 hwLine[ISM_LINE_PIN0])
    else $error("Rising edge on pin 1 was not reported.");

  sw_pend_a: assert property (  // see RULE4
    swSetPend[ISM_LINE_CONTACT] |=> pending[ISM_LINE_CONTACT])
    else $error("Software pending set was lost.");

  offer_enabled_a: assert property (  // see RULE1
    irqValid |-> lineEnable[irqNum] && pending[irqNum])
    else $error("Offered line is disabled or not pending.");

  take_level_a: assert property (  // see RULE2
    take_s |=> activeMask[$past(irqLevel)] && state == ST_IDLE)
    else $error("Acknowledge did not mark the level active.");

  ret_retire_a: assert property (  // see RULE2
    excReturn && !take_s && (activeLevel != ISM_NO_LEVEL)
      |=> !activeMask[$past(activeLevel[1:0])])
    else $error("A return did not retire the most urgent active level.");

  nest_mask_a: assert property (  // see RULE2
    take_s |-> ##2 (!irqValid || irqLevel < $past(irqLevel, 2)))
    else $error("A request at or below the active level was offered.");

endmodule : ism_interrupt_source_map
`default_nettype wire

// *** ism_core_model.sv ***
// Core model that takes offered lines, promptly or slowly, and may return.
`timescale 1ns/1ps
`default_nettype none

module ism_core_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Offer and handshake.
  input  wire logic       irqValid,
  input  wire logic [4:0] irqNum,
  output logic            irqAck,
  output logic            excReturn,
  // Bench control and record of takes.
  input  wire logic       nest,
  output logic [4:0]      takenNum,
  output int              takenCnt
);
  // Record each take at the edge that sees the handshake.
  always_ff @(posedge clk) begin
    if (rst) begin
      takenCnt <= 0;
    end else if (irqValid && irqAck) begin
      takenNum <= irqNum;
      takenCnt <= takenCnt + 1;
    end
  end

  // Ack spans one rising edge; a random stall mimics a busy core.
  initial begin
    irqAck = 1'b0;
    excReturn = 1'b0;
    forever begin
      @(negedge clk);
      excReturn = 1'b0;
      if (irqValid) begin
        repeat ($urandom_range(2)) @(negedge clk);
        irqAck = 1'b1;
        @(negedge clk);
        irqAck = 1'b0;
        // Without nesting the handler ends a cycle later.
        if (!nest) begin
          @(negedge clk);
          excReturn = 1'b1;
        end
      end
    end
  end
endmodule : ism_core_model

`default_nettype wire

// *** ism_interrupt_source_map_tb_top.sv ***
// Self-checking bench for the interrupt source map.
`timescale 1ns/1ps
`default_nettype none

module ism_interrupt_source_map_tb_top;
  import ism_pkg::*;
  logic        clk, rst, radioIrq, byteMemIrq, contactIrq, spiMasterIrq, twiMasterIrq;
  logic        watchdogIrq, irqValid, irqAck, excReturn, nmiReq, nest;
  logic [3:0]  timerIrq, hostBufIrq, powerIrq, activeMask;
  logic [5:0]  pcrIrq;
  logic [11:0] pinIn;
  logic [31:0] lineEnable, swSetPend, pendingOut;
  logic [4:0]  irqNum, takenNum;
  logic [1:0]  irqLevel;
  logic [1:0]  linePriority [ISM_LINES];
  ism_trig_t   pinMode [ISM_PINS];
  int          takenCnt, n_errors, checked, a, b, p;
  int          lines [9];

  ism_interrupt_source_map dut_u (.clk, .rst, .timerIrq, .radioIrq, .byteMemIrq, .hostBufIrq,
    .contactIrq, .powerIrq, .spiMasterIrq, .twiMasterIrq, .pcrIrq, .watchdogIrq, .pinIn,
    .pinMode, .lineEnable, .linePriority, .swSetPend, .irqValid, .irqNum, .irqLevel, .irqAck,
    .excReturn, .pendingOut, .activeMask, .nmiReq);
  ism_core_model core_u (.clk, .rst, .irqValid, .irqNum, .irqAck, .excReturn, .nest,
    .takenNum, .takenCnt);

  // Clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Compare two values and count the outcome.
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Quiet every input, draw priorities and hold reset for four cycles.
  task automatic do_reset();
    rst = 1'b1;
    {timerIrq, hostBufIrq, powerIrq, pcrIrq, pinIn} = '0;
    {radioIrq, byteMemIrq, contactIrq, spiMasterIrq, twiMasterIrq, watchdogIrq} = '0;
    {lineEnable, swSetPend, nest} = '0;
    foreach (pinMode[i]) pinMode[i] = TRIG_FALL;
    foreach (linePriority[i]) linePriority[i] = 2'($urandom);
    tick(4);
    rst = 1'b0;
  endtask : do_reset

  // One-cycle software pending pulse.
  task automatic pend(input logic [31:0] m);
    swSetPend = m;
    tick(1);
    swSetPend = '0;
  endtask : pend

  // Wait, bounded, for the n-th take and check its line.
  task automatic wait_take(input int n, input int exp);
    for (int i = 0; i < 40 && takenCnt != n; i++) tick(1);
    cmp(64'(takenCnt), 64'(n));
    cmp(64'(takenNum), 64'(exp));
  endtask : wait_take

  task automatic stop_test();
    $display("Comparisons: %0d, mismatches: %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Watchdog: the whole run needs well under ten thousand cycles.
  initial begin
    #40000;
    n_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(15));
    lines = '{0, 2, 3, 6, 7, 9, 10, 11, 12};
    n_errors = 0;
    checked = 0;
    do_reset();
    cmp({pendingOut, activeMask, irqValid, nmiReq}, '0);
    // Each peripheral request lands on its own line only.
    for (int k = 0; k < 9; k++) begin
      do_reset();
      p = $urandom_range(5);
      case (k)
        0: timerIrq[p % 4] = 1'b1;
        1: radioIrq = 1'b1;
        2: byteMemIrq = 1'b1;
        3: hostBufIrq[p % 4] = 1'b1;
        4: contactIrq = 1'b1;
        5: powerIrq[p % 4] = 1'b1;
        6: spiMasterIrq = 1'b1;
        7: twiMasterIrq = 1'b1;
        default: pcrIrq[p] = 1'b1;
      endcase
      tick(6);
      cmp(pendingOut, 64'h1 << lines[k]);
    end
    // Every trigger mode on a pin, random except for the rising case, raises its own line and the common one.
    for (int m = 0; m < 5; m++) begin
      do_reset();
      p = (m == 0) ? 0 : $urandom_range(11);
      // The mode is set well before the pin moves, so the rising case on pin 1 is seen.
      pinMode[p] = ism_trig_t'(m);
      pinIn[p] = (m == 1 || m == 4);
      tick(6);
      pinIn[p] = ~pinIn[p];
      tick(6);
      cmp(pendingOut, (64'h1 << 13) | (64'h1 << (14 + p)));
    end
    // Reserved lines ignore software set; the watchdog feeds only the non-maskable output.
    do_reset();
    watchdogIrq = 1'b1;
    pend(32'hfc00_013a);
    tick(1);
    cmp(nmiReq, 0);
    tick(1);
    cmp(nmiReq, 1);
    tick(2);
    cmp(pendingOut, 32'h8);
    // Two lines set together are served most urgent first, ties to the lower number.
    repeat (6) begin
      do_reset();
      lineEnable = '1;
      a = lines[$urandom_range(8)];
      b = 14 + $urandom_range(11);
      pend((32'h1 << a) | (32'h1 << b));
      p = (linePriority[b] < linePriority[a]) ? b : a;
      wait_take(1, p);
      wait_take(2, a + b - p);
      tick(4);
      cmp({pendingOut, activeMask}, '0);
    end
    // A nested handler masks lines of its own level; a disabled line waits.
    do_reset();
    nest = 1'b1;
    lineEnable = 32'hffff_fffb;
    linePriority[7] = 2'h1;
    linePriority[9] = 2'h1;
    linePriority[2] = 2'h0;
    pend(32'h80);
    wait_take(1, 7);
    cmp(activeMask, 4'h2);
    cmp(64'(irqLevel), 64'h1);
    pend(32'h204);
    tick(10);
    cmp(64'(takenCnt), 64'h1);
    cmp(pendingOut, 32'h204);
    lineEnable = '1;
    wait_take(2, 2);
    cmp(activeMask, 4'h3);
    stop_test();
  end
endmodule : ism_interrupt_source_map_tb_top

`default_nettype wire
